// *** verilog/tpd_pkg.sv ***
// tpd_pkg: shared constants and types of the pwm and dead-time block
package tpd_pkg;
  localparam int CNT_W = 16;
  localparam int NCH   = 3;
  localparam int KEY_W = 16;
  localparam int EXP_W = 4;
  localparam int DIV_W = 10;
  localparam int DLY_W = 6;

  localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'hce80;
  localparam logic [EXP_W-1:0] EXP_MAX    = 4'ha;
  localparam logic [DIV_W:0]   DIV_ONE    = 11'h001;
  localparam logic [DIV_W-1:0] DIV_NONE   = 10'h000;
  localparam logic [CNT_W-1:0] STEP_1X    = 16'h0001;
  localparam logic [CNT_W-1:0] STEP_2X    = 16'h0002;
  localparam logic [CNT_W-1:0] EVEN_MASK  = 16'hfffe;
  localparam logic [DLY_W:0]   DLY_ONE    = 7'h01;
  // reset count of one lets the low side come on after the first tick
  localparam logic [DLY_W:0]   DLY_RST    = 7'h01;
  localparam logic             RST_LOCKED = 1'h0;
  localparam logic             RST_DRIVE  = 1'h1;

  typedef enum logic [1:0] {CM_UP, CM_DOWN, CM_UPDOWN} tpd_cmode_type;
  typedef enum logic [1:0] {
    SF_INACTIVE, SF_CLEAR, SF_TRISTATE
  } tpd_safe_type;
endpackage : tpd_pkg

// *** verilog/tpd_dt_if.sv ***
// tpd_dt_if: links the top to the per-channel dead-time stages
interface tpd_dt_if #(parameter int NCH = tpd_pkg::NCH);
  logic                      tick;
  logic [tpd_pkg::DLY_W-1:0] rise;
  logic [tpd_pkg::DLY_W-1:0] fall;
  logic                      src [NCH];
  logic                      run [NCH];
  logic                      pri [NCH];
  logic                      cmp [NCH];
  modport ctl  (output tick, rise, fall, src, run, input pri, cmp);
  modport chan (input tick, rise, fall, src, run, output pri, cmp);
endinterface : tpd_dt_if

// *** verilog/tpd_tick_gen.sv ***
// tpd_tick_gen: divides the clock into one-cycle ticks, factor div_m1+1
module tpd_tick_gen #(
  parameter int W = tpd_pkg::DIV_W
) (
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] div_m1_in,
  output logic              tick_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tpd_tick_state_type;

  tpd_tick_state_type s;
  tpd_tick_state_type next_s;

  always_comb begin
    next_s      = s;
    // >= so that a divider shrunk mid-count never stalls the ticks
    next_s.tick = (s.cnt >= div_m1_in);
    next_s.cnt  = next_s.tick ? '0 : s.cnt + W'(1);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;
endmodule : tpd_tick_gen

// *** verilog/tpd_dt_channel.sv ***
// tpd_dt_channel: dead-time stage of one pwm pair, active-high levels
module tpd_dt_channel #(
  parameter int IDX = 0
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  tpd_dt_if.chan   dt
);
  typedef struct packed {
    logic                    src_q;
    logic [tpd_pkg::DLY_W:0] cnt;
    logic                    pri;
    logic                    cmp;
  } tpd_chan_state_type;

  tpd_chan_state_type s;
  tpd_chan_state_type next_s;

  always_comb begin
    next_s = s;
    if (dt.run[IDX]) begin
      if (dt.src[IDX] != s.src_q) begin
        next_s.src_q = dt.src[IDX];
        next_s.pri   = 1'h0; // RL15
        next_s.cmp   = 1'h0; // RL15
        next_s.cnt   = dt.src[IDX]
                       ? {1'h0, dt.rise} + tpd_pkg::DLY_ONE  // RL16 RL18
                       : {1'h0, dt.fall} + tpd_pkg::DLY_ONE; // RL16 RL18
      end else if (dt.tick && s.cnt != '0) begin
        next_s.cnt = s.cnt - tpd_pkg::DLY_ONE;
        if (s.cnt == tpd_pkg::DLY_ONE) begin
          next_s.pri = s.src_q;
          next_s.cmp = !s.src_q; // RL13
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s     <= '0;
      s.cnt <= tpd_pkg::DLY_RST;
    end else begin
      s <= next_s;
    end
  end

  assign dt.pri[IDX] = s.pri;
  assign dt.cmp[IDX] = s.cmp;

  default clocking cb_chan @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  property p_pair_apart;
    !(s.pri && s.cmp);
  endproperty
  a_pair_apart: assert property (p_pair_apart) else $error("pair both on"); // RL15

  property p_edge_gap;
    (dt.run[IDX] && dt.src[IDX] != s.src_q) |=> !s.pri && !s.cmp;
  endproperty
  a_edge_gap: assert property (p_edge_gap) else $error("no gap on edge"); // RL15
endmodule : tpd_dt_channel

// *** verilog/tpd_top.sv ***
// tpd_top: pwm timer with configuration lock and dead-time insertion
// Operation
// RL1: up-count period is period_limit+1 cycles, high for compare_value cycles.
// RL2: up-count output stays high when compare_value >= period_limit+1.
// RL3: up-count frequency is clock / 2^exp / (period_limit+1).
// RL4: 2x up-count steps by two; odd period_limit acts as next lower even.
// RL5: in 2x modes an odd compare_value matches at the lower even count.
// RL6: 2x up-count duty is compare_value / (2*(floor(period_limit/2)+1)).
// RL7: up/down counting with pwm gives dual-slope, duty compare/period_limit.
// RL8: dual-slope frequency is clock / 2^(exp+1) / period_limit.
// RL9: 2x up/down steps by two both ways; odd period_limit rounds down.
// RL10: a wrong key locks control, command, period, counter and compare.
// RL11: writing the unlock key reopens the protected settings.
// RL12: lock status reads one while locked, zero while writable.
// RL13: each of three channels gets a complementary output beside its primary.
// RL14: with deadtime_enable the gap_inserter drives the primary pins too.
// RL15: rising edges of both outputs are delayed; pair is off in the gap.
// RL16: separate rise and fall delays, shared by channels and one prescaler.
// RL17: deadtime_divider divides the clock by 1 to 1024.
// RL18: rise_delay and fall_delay each select 1 to 64 prescaled cycles.
// RL19: gap_inserter stops with the timer; keep_ch0_running keeps channel 0.
// RL20: with keep_ch0_running, dead-times use the undivided clock.
// RL21: on stop with neither option set, outputs freeze at last levels.
// RL22: safe_on_halt sends stopped outputs to the chosen safe state. Here this happens only while deadtime_enable is set.
// RL23: compare_buffer moves to compare_value only on an update event.
// RL24: pwm only in up or up/down counting; no compare actions in pwm.
// RL25: compare output lags the match by one cycle for 0 to 100 percent.
// RL26: base_polarity sets both outputs' level; invert flips the complement. Here both apply only while deadtime_enable is set.
// RL27: up-count wraps period_limit to zero; output high at period start.
module tpd_top (
  input  wire logic                          mclk_in,
  input  wire logic                          arst_n_in,
  input  wire logic                          key_we_in,
  input  wire logic [tpd_pkg::KEY_W-1:0]     key_in,
  input  wire logic                          cfg_we_in,
  input  wire logic                          cfg_run_in,
  input  wire tpd_pkg::tpd_cmode_type        cfg_cmode_in,
  input  wire logic                          cfg_x2_in,
  input  wire logic [tpd_pkg::EXP_W-1:0]     cfg_exp_in,
  input  wire logic [tpd_pkg::NCH-1:0]       cfg_pwm_en_in,
  input  wire logic [tpd_pkg::CNT_W-1:0]     cfg_top_in,
  input  wire logic [tpd_pkg::CNT_W-1:0]     cfg_count_in,
  input  wire logic [tpd_pkg::NCH*tpd_pkg::CNT_W-1:0] cfg_compare_in,
  input  wire logic                          deadtime_enable_in,
  input  wire logic [tpd_pkg::DIV_W-1:0]     deadtime_divider_in,
  input  wire logic [tpd_pkg::DLY_W-1:0]     rise_delay_in,
  input  wire logic [tpd_pkg::DLY_W-1:0]     fall_delay_in,
  input  wire logic                          keep_ch0_running_in,
  input  wire logic                          safe_on_halt_in,
  input  wire tpd_pkg::tpd_safe_type         fault_action_select_in,
  input  wire logic                          base_polarity_in,
  input  wire logic                          complementary_invert_in,
  output logic                               lock_active_out,
  output logic                               timer_running_out,
  output logic [tpd_pkg::CNT_W-1:0]          count_out,
  output logic [tpd_pkg::NCH-1:0]            buffer_pending_out,
  output logic [tpd_pkg::NCH-1:0]            primary_out,
  output logic [tpd_pkg::NCH-1:0]            complementary_out,
  output logic [tpd_pkg::NCH-1:0]            pair_drive_out
);
  localparam int NCH   = tpd_pkg::NCH;
  localparam int CNT_W = tpd_pkg::CNT_W;

  typedef struct packed {
    logic                            locked;
    logic                            run;
    tpd_pkg::tpd_cmode_type          cmode;
    logic                            x2;
    logic [tpd_pkg::EXP_W-1:0]       exp;
    logic [NCH-1:0]                  pwm_en;
    logic [CNT_W-1:0]                top;
    logic [CNT_W-1:0]                cnt;
    logic                            down;
    logic                            upd;
    logic [NCH-1:0][CNT_W-1:0]       cv;
    logic [NCH-1:0][CNT_W-1:0]       cb;
    logic [NCH-1:0]                  cbv;
    logic [NCH-1:0]                  pwm;
    logic [NCH-1:0]                  pri;
    logic [NCH-1:0]                  cmp;
    logic [NCH-1:0]                  oe;
  } tpd_top_state_type;

  tpd_top_state_type s;
  tpd_top_state_type next_s;

  tpd_dt_if #(.NCH(NCH)) dt ();

  logic                        tmr_tick;
  logic [tpd_pkg::EXP_W-1:0]   exp_c;
  logic [tpd_pkg::DIV_W:0]     tmr_pow;
  logic [tpd_pkg::DIV_W-1:0]   tmr_div_m1;
  logic [tpd_pkg::DIV_W-1:0]   dt_div_m1;
  logic [CNT_W-1:0]            te;
  logic [CNT_W-1:0]            step;
  logic [CNT_W:0]              up_sum;
  logic [NCH-1:0]              hi;
  logic [NCH-1:0]              chan_run;
  logic [CNT_W-1:0]            ce [NCH];

  // timer prescaler: divide by 2^exp, clamped at the largest setting
  assign exp_c = (s.exp > tpd_pkg::EXP_MAX) ? tpd_pkg::EXP_MAX : s.exp;
  assign tmr_pow    = tpd_pkg::DIV_ONE << exp_c; // RL3 RL8
  assign tmr_div_m1 = tpd_pkg::DIV_W'(tmr_pow - tpd_pkg::DIV_ONE);

  tpd_tick_gen #(.W(tpd_pkg::DIV_W)) u_tmr_tick (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .div_m1_in (tmr_div_m1),
    .tick_out  (tmr_tick)
  );

  // channel 0 kept alive uses the undivided clock for its gaps
  assign dt_div_m1 = keep_ch0_running_in ? tpd_pkg::DIV_NONE // RL20
                                         : deadtime_divider_in; // RL17

  tpd_tick_gen #(.W(tpd_pkg::DIV_W)) u_dt_tick (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .div_m1_in (dt_div_m1),
    .tick_out  (dt.tick)
  );

  assign dt.rise = rise_delay_in; // RL16
  assign dt.fall = fall_delay_in; // RL16

  // odd limits act as the next lower even value in 2x counting
  assign te     = s.x2 ? (s.top & tpd_pkg::EVEN_MASK) : s.top; // RL4 RL9
  assign step   = s.x2 ? tpd_pkg::STEP_2X : tpd_pkg::STEP_1X; // RL4 RL9
  assign up_sum = {1'h0, s.cnt} + {1'h0, step};

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign ce[g] = s.x2 ? (s.cv[g] & tpd_pkg::EVEN_MASK) : s.cv[g]; // RL5
    // down slope compares inclusively so duty is compare/period_limit
    assign hi[g] = s.down ? (s.cnt <= ce[g]) : (s.cnt < ce[g]); // RL1 RL6 RL7
    assign chan_run[g] = s.run || (g == 0 && keep_ch0_running_in); // RL19
    assign dt.src[g] = s.pwm[g];
    assign dt.run[g] = chan_run[g]; // RL19

    tpd_dt_channel #(.IDX(g)) u_chan (
      .mclk_in   (mclk_in),
      .arst_n_in (arst_n_in),
      .dt        (dt.chan)
    ); // RL13
  end

  always_comb begin
    next_s     = s;
    next_s.upd = 1'h0;

    if (key_we_in) begin
      next_s.locked = (key_in != tpd_pkg::UNLOCK_KEY); // RL10 RL11
    end

    if (s.run && tmr_tick) begin
      case (s.cmode)
        tpd_pkg::CM_UP: begin
          if (s.cnt >= te) begin
            next_s.cnt = '0; // RL27
            next_s.upd = 1'h1;
          end else begin
            next_s.cnt = s.cnt + step;
          end
        end
        tpd_pkg::CM_UPDOWN: begin
          if (!s.down) begin
            if (up_sum >= {1'h0, te}) begin
              next_s.cnt  = te;
              next_s.down = 1'h1;
            end else begin
              next_s.cnt = up_sum[CNT_W-1:0];
            end
          end else if (s.cnt <= step) begin
            next_s.cnt  = '0; // RL9
            next_s.down = 1'h0;
            next_s.upd  = 1'h1;
          end else begin
            next_s.cnt = s.cnt - step; // RL9
          end
        end
        tpd_pkg::CM_DOWN: begin
          next_s.down = 1'h0;
          if (s.cnt == '0) begin
            next_s.cnt = te;
            next_s.upd = 1'h1;
          end else if (s.cnt < step) begin
            next_s.cnt = '0;
          end else begin
            next_s.cnt = s.cnt - step;
          end
        end
        default: begin
          next_s.cnt  = '0;
          next_s.down = 1'h0;
        end
      endcase
    end

    // buffered compare moves only at the update event, no output glitch
    if (next_s.upd) begin
      for (int i = 0; i < NCH; i++) begin
        if (s.cbv[i]) begin
          next_s.cv[i]  = s.cb[i]; // RL23
          next_s.cbv[i] = 1'h0;
        end
      end
    end

    // a write landing on the update cycle re-arms the buffer afterwards
    if (cfg_we_in && !s.locked) begin // RL10
      next_s.run    = cfg_run_in;
      next_s.cmode  = cfg_cmode_in;
      next_s.x2     = cfg_x2_in;
      next_s.exp    = cfg_exp_in;
      next_s.pwm_en = cfg_pwm_en_in;
      next_s.top    = cfg_top_in;
      next_s.cnt    = cfg_count_in;
      next_s.down   = 1'h0;
      for (int i = 0; i < NCH; i++) begin
        next_s.cb[i]  = cfg_compare_in[i*CNT_W +: CNT_W];
        next_s.cbv[i] = 1'h1;
      end
    end

    for (int i = 0; i < NCH; i++) begin
      // registered match output: the one-cycle lag reaches 0 and 100 %
      next_s.pwm[i] = s.pwm_en[i] && hi[i] // RL25
                      && s.cmode != tpd_pkg::CM_DOWN; // RL24
      if (!deadtime_enable_in) begin
        next_s.pri[i] = s.pwm[i];
        next_s.cmp[i] = 1'h0;
        next_s.oe[i]  = 1'h1;
      end else if (chan_run[i]) begin
        next_s.pri[i] = dt.pri[i] ^ base_polarity_in; // RL14 RL26
        next_s.cmp[i] = dt.cmp[i] ^ base_polarity_in
                        ^ complementary_invert_in; // RL26
        next_s.oe[i]  = 1'h1;
      end else if (safe_on_halt_in) begin
        case (fault_action_select_in)
          tpd_pkg::SF_INACTIVE: begin
            next_s.pri[i] = base_polarity_in; // RL22
            next_s.cmp[i] = base_polarity_in ^ complementary_invert_in;
            next_s.oe[i]  = 1'h1;
          end
          tpd_pkg::SF_CLEAR: begin
            next_s.pri[i] = 1'h0; // RL22
            next_s.cmp[i] = 1'h0;
            next_s.oe[i]  = 1'h1;
          end
          tpd_pkg::SF_TRISTATE: begin
            next_s.oe[i] = 1'h0; // RL22
          end
          default: begin
            next_s.oe[i] = 1'h0;
          end
        endcase
      end
      // otherwise stopped and unsafe: pins keep their last level RL21
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s        <= '0;
      s.locked <= tpd_pkg::RST_LOCKED;
      s.oe     <= {NCH{tpd_pkg::RST_DRIVE}};
    end else begin
      s <= next_s;
    end
  end

  assign lock_active_out    = s.locked; // RL12
  assign timer_running_out  = s.run;
  assign count_out          = s.cnt;
  assign buffer_pending_out = s.cbv;
  assign primary_out        = s.pri;
  assign complementary_out  = s.cmp;
  assign pair_drive_out     = s.oe;

  default clocking cb_main @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  property p_lock_set;
    key_we_in && key_in != tpd_pkg::UNLOCK_KEY |=> lock_active_out;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("not locked"); // RL10

  property p_lock_clr;
    key_we_in && key_in == tpd_pkg::UNLOCK_KEY |=> !lock_active_out;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("not open"); // RL12

  property p_locked_hold;
    s.locked && !key_we_in && cfg_we_in |=> $stable(s.top) && $stable(s.cb);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("lock leak"); // RL10

  property p_wrap_up;
    s.run && tmr_tick && s.cmode == tpd_pkg::CM_UP && s.cnt >= te
      && !(cfg_we_in && !s.locked) |=> s.cnt == '0 && s.upd;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("no wrap"); // RL27

  property p_cv_only_on_upd;
    !s.upd |-> s.cv == $past(s.cv);
  endproperty
  a_cv_only_on_upd: assert property (p_cv_only_on_upd) else $error("cv moved"); // RL23

  property p_full_high;
    s.cmode == tpd_pkg::CM_UP && !s.x2 && s.pwm_en[1] && s.cnt <= s.top
      && s.cv[1] > s.top |=> s.pwm[1];
  endproperty
  a_full_high: assert property (p_full_high) else $error("not full"); // RL2

  property p_zero_low;
    s.cv[0] == '0 |=> !s.pwm[0];
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("not zero"); // RL1

  property p_no_down_pwm;
    s.cmode == tpd_pkg::CM_DOWN |=> s.pwm == '0;
  endproperty
  a_no_down_pwm: assert property (p_no_down_pwm) else $error("down pwm"); // RL24

  property p_freeze;
    deadtime_enable_in && !s.run && !keep_ch0_running_in
      && !safe_on_halt_in |=> s.pri == $past(s.pri) && s.cmp == $past(s.cmp);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen"); // RL21

  property p_safe_clear;
    deadtime_enable_in && !s.run && !keep_ch0_running_in && safe_on_halt_in
      && fault_action_select_in == tpd_pkg::SF_CLEAR |=> !s.pri[0] && !s.cmp[0];
  endproperty
  a_safe_clear: assert property (p_safe_clear) else $error("not safe"); // RL22

  property p_safe_tri;
    deadtime_enable_in && !s.run && !keep_ch0_running_in && safe_on_halt_in
      && fault_action_select_in == tpd_pkg::SF_TRISTATE |=> !s.oe[0];
  endproperty
  a_safe_tri: assert property (p_safe_tri) else $error("still driven"); // RL22

  property p_up_bound;
    s.run && s.cmode == tpd_pkg::CM_UP && !s.x2 && s.cnt <= s.top
      && !cfg_we_in |=> s.cnt <= s.top;
  endproperty
  a_up_bound: assert property (p_up_bound) else $error("past top"); // RL1
endmodule : tpd_top

// *** testbench/tpd_bridge_model.sv ***
// tpd_bridge_model: three half-bridges that count shoot-through cycles
module tpd_bridge_model (
  input  wire logic       mclk_in,
  input  wire logic [2:0] high_gate_in,
  input  wire logic [2:0] low_gate_in,
  input  wire logic [2:0] drive_in,
  input  wire logic       base_polarity_in,
  input  wire logic       complementary_invert_in,
  output int              overlap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hi_on;
  logic [2:0] lo_on;
  logic       lo_pol;
  int         ov = 0;
  assign overlap_out = ov;
  assign lo_pol = base_polarity_in ^ complementary_invert_in;
  // undriven pairs cannot conduct, so only driven gates count
  assign hi_on = (high_gate_in ^ {3{base_polarity_in}}) & drive_in;
  assign lo_on = (low_gate_in ^ {3{lo_pol}}) & drive_in;
  always @(posedge mclk_in)
    if ((hi_on & lo_on) != 3'b000)
      ov <= ov + 1;
endmodule : tpd_bridge_model

// *** testbench/tb_timer_pwm_deadtime.sv ***
// tb_timer_pwm_deadtime: self-checking bench of the pwm and dead-time block
module tb_timer_pwm_deadtime;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk_in = 1'b0;
  logic                   arst_n_in = 1'b0;
  logic                   key_we_in = 1'b0;
  logic [15:0]            key_in = 16'h0000;
  logic                   cfg_we_in = 1'b0;
  logic                   cfg_run_in = 1'b0;
  tpd_pkg::tpd_cmode_type cfg_cmode_in = tpd_pkg::CM_UP;
  logic                   cfg_x2_in = 1'b0;
  logic [3:0]             cfg_exp_in = 4'h0;
  logic [2:0]             cfg_pwm_en_in = 3'h7;
  logic [15:0]            cfg_top_in = 16'h0000;
  logic [15:0]            cfg_count_in = 16'h0000;
  logic [47:0]            cfg_compare_in = 48'h0000_0000_0000;
  logic                   deadtime_enable_in = 1'b0;
  logic [9:0]             deadtime_divider_in = 10'h000;
  logic [5:0]             rise_delay_in = 6'h01;
  logic [5:0]             fall_delay_in = 6'h03;
  logic                   keep_ch0_running_in = 1'b0;
  logic                   safe_on_halt_in = 1'b0;
  tpd_pkg::tpd_safe_type  fault_action_select_in = tpd_pkg::SF_INACTIVE;
  logic                   base_polarity_in = 1'b0;
  logic                   complementary_invert_in = 1'b0;
  logic                   lock_active_out;
  logic                   timer_running_out;
  logic [15:0]            count_out;
  logic [2:0]             buffer_pending_out;
  logic [2:0]             primary_out;
  logic [2:0]             complementary_out;
  logic [2:0]             pair_drive_out;
  int                     overlap;
  int                     n_fail = 0;
  int                     compares = 0;
  int                     hp[3];
  int                     hc[3];
  int                     ed;
  int                     mx;

  always #12.5 mclk_in = ~mclk_in;

  tpd_top dut (.mclk_in, .arst_n_in, .key_we_in, .key_in, .cfg_we_in,
    .cfg_run_in, .cfg_cmode_in, .cfg_x2_in, .cfg_exp_in, .cfg_pwm_en_in,
    .cfg_top_in, .cfg_count_in, .cfg_compare_in, .deadtime_enable_in,
    .deadtime_divider_in, .rise_delay_in, .fall_delay_in,
    .keep_ch0_running_in, .safe_on_halt_in, .fault_action_select_in,
    .base_polarity_in, .complementary_invert_in, .lock_active_out,
    .timer_running_out, .count_out, .buffer_pending_out, .primary_out,
    .complementary_out, .pair_drive_out);

  tpd_bridge_model bridge (.mclk_in, .high_gate_in(primary_out),
    .low_gate_in(complementary_out), .drive_in(pair_drive_out),
    .base_polarity_in, .complementary_invert_in, .overlap_out(overlap));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  task automatic key(input logic [15:0] v);
    @(posedge mclk_in);
    key_we_in <= 1'b1;
    key_in    <= v;
    @(posedge mclk_in);
    key_we_in <= 1'b0;
    @(negedge mclk_in);
  endtask : key

  task automatic cfg(input logic run, input tpd_pkg::tpd_cmode_type md,
                     input logic x2, input logic [3:0] ex,
                     input logic [15:0] top, input logic [47:0] cv);
    @(posedge mclk_in);
    cfg_we_in      <= 1'b1;
    cfg_run_in     <= run;
    cfg_cmode_in   <= md;
    cfg_x2_in      <= x2;
    cfg_exp_in     <= ex;
    cfg_top_in     <= top;
    cfg_compare_in <= cv;
    @(posedge mclk_in);
    cfg_we_in <= 1'b0;
    @(negedge mclk_in);
  endtask : cfg

  // counts a whole number of periods, so the phase of the window is moot
  task automatic meas(input int n);
    logic prev;
    cyc(40);
    @(negedge mclk_in);
    prev = primary_out[0];
    hp = '{default: 0};
    hc = '{default: 0};
    ed = 0;
    mx = 0;
    repeat (n) begin
      @(negedge mclk_in);
      for (int i = 0; i < 3; i++) begin
        hp[i] += int'(primary_out[i] === 1'b1);
        hc[i] += int'(complementary_out[i] === 1'b1);
      end
      ed += int'(primary_out[0] === 1'b1 && prev === 1'b0);
      prev = primary_out[0];
      if (int'(count_out) > mx) mx = int'(count_out);
    end
    @(posedge mclk_in);
  endtask : meas

  task automatic t_lock;
    chk(16'(pair_drive_out), 16'h0007);
    key(16'h1234);
    chk(16'(lock_active_out), 16'h0001);
    @(posedge mclk_in);
    cfg_count_in <= 16'h0007;
    cfg(1'b1, tpd_pkg::CM_UP, 1'b0, 4'h0, 16'h0003, 48'h0000_0000_0000);
    chk(16'(timer_running_out), 16'h0000);
    chk(count_out, 16'h0000);
    key(16'hce80);
    chk(16'(lock_active_out), 16'h0000);
    cfg(1'b0, tpd_pkg::CM_UP, 1'b0, 4'h0, 16'h0003, 48'h0000_0000_0000);
    chk(count_out, 16'h0007);
    @(posedge mclk_in);
    cfg_count_in <= 16'h0000;
  endtask : t_lock

  task automatic t_counting;
    cfg(1'b1, tpd_pkg::CM_UP, 1'b0, 4'h0, 16'h0003, 48'h0000_0004_0002);
    meas(16);
    chk(16'(hp[0]), 16'h0008);
    chk(16'(hp[1]), 16'h0010);
    chk(16'(hp[2]), 16'h0000);
    chk(16'(ed), 16'h0004);
    chk(16'(mx), 16'h0003);
    chk(16'(hc[0]), 16'h0000);
    cfg(1'b1, tpd_pkg::CM_UP, 1'b0, 4'h1, 16'h0003, 48'h0000_0004_0002);
    meas(32);
    chk(16'(ed), 16'h0004);
    chk(16'(hp[0]), 16'h0010);
    cfg(1'b1, tpd_pkg::CM_DOWN, 1'b0, 4'h0, 16'h0003, 48'h0000_0004_0002);
    meas(16);
    chk(16'(hp[0]), 16'h0000);
    cfg(1'b1, tpd_pkg::CM_UP, 1'b1, 4'h0, 16'h0005, 48'h0000_0003_0002);
    meas(30);
    chk(16'(hp[0]), 16'h000a);
    chk(16'(hp[1]), 16'h000a);
    chk(16'(mx), 16'h0004);
    cfg(1'b1, tpd_pkg::CM_UPDOWN, 1'b0, 4'h0, 16'h0004, 48'h0000_0000_0002);
    meas(32);
    chk(16'(hp[0]), 16'h0010);
    chk(16'(ed), 16'h0004);
    cfg(1'b1, tpd_pkg::CM_UPDOWN, 1'b1, 4'h0, 16'h0005, 48'h0000_0000_0002);
    meas(32);
    chk(16'(mx), 16'h0004);
  endtask : t_counting

  task automatic t_buffer;
    int k;
    k = 0;
    cfg(1'b1, tpd_pkg::CM_UP, 1'b0, 4'h0, 16'h000f, 48'h0008_0008_0008);
    chk(16'(buffer_pending_out), 16'h0007);
    while (buffer_pending_out !== 3'b000 && k < 20) begin
      @(negedge mclk_in);
      k++;
    end
    chk(16'(buffer_pending_out), 16'h0000);
  endtask : t_buffer

  task automatic t_deadtime;
    @(posedge mclk_in);
    deadtime_enable_in <= 1'b1;
    meas(32);
    chk(16'(hp[0]), 16'h000c);
    chk(16'(hc[0]), 16'h0008);
    chk(16'(hc[2]), 16'h0008);
    chk(16'(overlap), 16'h0000);
    // a coarse divider would smear the gap; keep must restore exact timing
    deadtime_divider_in <= 10'h003;
    keep_ch0_running_in <= 1'b1;
    meas(32);
    chk(16'(hp[0]), 16'h000c);
    chk(16'(hc[0]), 16'h0008);
    keep_ch0_running_in <= 1'b0;
    deadtime_divider_in <= 10'h000;
    base_polarity_in <= 1'b1;
    meas(32);
    chk(16'(hp[0]), 16'h0014);
    chk(16'(hc[0]), 16'h0018);
    base_polarity_in <= 1'b0;
    complementary_invert_in <= 1'b1;
    meas(32);
    chk(16'(hp[0]), 16'h000c);
    chk(16'(hc[0]), 16'h0018);
    complementary_invert_in <= 1'b0;
  endtask : t_deadtime

  task automatic t_halt;
    logic [5:0] snap;
    cyc(40);
    cfg(1'b0, tpd_pkg::CM_UP, 1'b0, 4'h0, 16'h000f, 48'h0008_0008_0008);
    cyc(5);
    snap = {primary_out, complementary_out};
    cyc(20);
    chk(16'({primary_out, complementary_out}), 16'(snap));
    safe_on_halt_in <= 1'b1;
    base_polarity_in <= 1'b1;
    cyc(3);
    chk(16'({primary_out, complementary_out}), 16'h003f);
    base_polarity_in <= 1'b0;
    fault_action_select_in <= tpd_pkg::SF_CLEAR;
    cyc(3);
    chk(16'({primary_out, complementary_out}), 16'h0000);
    chk(16'(pair_drive_out), 16'h0007);
    fault_action_select_in <= tpd_pkg::SF_TRISTATE;
    cyc(3);
    chk(16'(pair_drive_out), 16'h0000);
    keep_ch0_running_in <= 1'b1;
    cyc(3);
    chk(16'(pair_drive_out), 16'h0001);
  endtask : t_halt

  initial begin
    #100us;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_lock();
    t_counting();
    t_buffer();
    t_deadtime();
    t_halt();
    conclude();
  end
endmodule : tb_timer_pwm_deadtime
